// *** design/cae_core.v ***
`timescale 1ns/100ps
`include "cae_defines.vh"

module cae_core #(
	parameter [15:0] PROG_BYTES = `CAE_PROG_BYTES
) (
	input  wire        i_clk,
	input  wire        i_reset_n,
	output reg  [14:0] o_prog_addr,
	output reg         o_prog_rd,
	input  wire [7:0]  i_prog_data,
	output reg  [7:0]  o_dmem_addr,
	output reg         o_dmem_rd,
	output reg         o_dmem_wr,
	output reg  [7:0]  o_dmem_wdata,
	input  wire [7:0]  i_dmem_rdata,
	input  wire        i_dmem_hit,
	output reg  [7:0]  o_acc,
	output reg  [14:0] o_pc,
	output reg         o_carry,
	output reg         o_half_carry,
	output reg         o_global_irq_enable
);

	localparam [11:0] S_IF  = 12'h001;
	localparam [11:0] S_IW  = 12'h002;
	localparam [11:0] S_IG  = 12'h004;
	localparam [11:0] S_ADR = 12'h008;
	localparam [11:0] S_DRQ = 12'h010;
	localparam [11:0] S_DW  = 12'h020;
	localparam [11:0] S_DG  = 12'h040;
	localparam [11:0] S_EXE = 12'h080;
	localparam [11:0] S_WR  = 12'h100;
	localparam [11:0] S_TQ  = 12'h200;
	localparam [11:0] S_TW  = 12'h400;
	localparam [11:0] S_TG  = 12'h800;

	reg  [11:0]  st_r;
	reg  [7:0]   opc_r;
	reg  [7:0]   op1_r;
	reg  [7:0]   op2_r;
	reg  [1:0]   cnt_r;
	reg  [1:0]   need_r;
	reg          skip_r;
	reg  [7:0]   daddr_r;
	reg  [1:0]   rdl_r;
	reg  [7:0]   opnd_r;
	reg  [7:0]   opnd2_r;
	reg  [7:0]   wa0_r;
	reg  [7:0]   wd0_r;
	reg  [7:0]   wa1_r;
	reg  [7:0]   wd1_r;
	reg  [1:0]   wcnt_r;
	reg          lsub_r;
	reg  [127:0] rf_r;

	wire [3:0]  hi     = opc_r[7:4];
	wire [3:0]  lo     = opc_r[3:0];
	wire [7:0]  reg_b  = rf_r[{`CAE_IDX_B, 3'b000} +: 8];
	wire [7:0]  reg_x  = rf_r[{`CAE_IDX_X, 3'b000} +: 8];
	wire [7:0]  stkp   = rf_r[{`CAE_IDX_STK, 3'b000} +: 8];
	wire [7:0]  ptr    = (hi == `CAE_G_PTRX) ? reg_x : reg_b;
	wire        pmode  = (lo[2:0] == 3'h2) || (lo[2:0] == 3'h3) || (lo[2:0] == 3'h6);
	wire        pstep  = pmode && (lo[2:1] == 2'b01);
	wire        is_reg = (daddr_r[7:4] == `CAE_REG_PAGE);
	wire [7:0]  m      = (hi == `CAE_G_ALUI) ? op1_r : opnd_r;
	wire [7:0]  bmask  = 8'h01 << lo[2:0];
	wire        is_pop = (opc_r == `CAE_OP_EXIT_SK) || (opc_r == `CAE_OP_EXIT)
			|| (opc_r == `CAE_OP_IRQ_EXIT);

	// absent program bytes read as the trap opcode so a runaway fetch traps
	wire [7:0]  pb = ({1'b0, o_prog_addr} < PROG_BYTES) ? i_prog_data
			: `CAE_TRAP_OPC;
	// register page is internal; absent external bytes read as all ones
	wire [7:0]  dval = is_reg ? rf_r[{daddr_r[3:0], 3'b000} +: 8]
			: (i_dmem_hit ? i_dmem_rdata : `CAE_DATA_FILL);

	// extra instruction bytes after the opcode
	function [1:0] op_len;
		input [7:0] o;
		begin
			case (o[7:4])
			`CAE_G_AJUMP, `CAE_G_ACALL, `CAE_G_ALUI, `CAE_G_LDREG: op_len = 2'd1;
			default: op_len = (o == `CAE_OP_LJUMP || o == `CAE_OP_LCALL
					|| o == `CAE_OP_LDMDI) ? 2'd2 : 2'd0;
			endcase
		end
	endfunction

	// operand address and read count per opcode
	reg [1:0] rd_c;
	reg [7:0] da_c;
	always @* begin
		rd_c = 2'd0;
		da_c = ptr;
		case (hi)
		`CAE_G_MISC: if (lo[3]) rd_c = 2'd1;
		`CAE_G_BIT: rd_c = 2'd1;
		`CAE_G_ALUB: begin
			if (!lo[3]) begin
				rd_c = 2'd1;
			end else if (is_pop) begin
				rd_c = 2'd2;
				da_c = stkp + 8'h01;
			end
		end
		`CAE_G_ALUI: begin
			if (opc_r == `CAE_OP_XMD || opc_r == `CAE_OP_LDAMD) begin
				rd_c = 2'd1;
				da_c = op1_r;
			end
		end
		`CAE_G_PTRB, `CAE_G_PTRX: if (pmode) rd_c = 2'd1;
		`CAE_G_DECSK: begin
			rd_c = 2'd1;
			da_c = {`CAE_REG_PAGE, lo};
		end
		default: ;
		endcase
	end

	// adder shared by add-with-carry and sub_borrow
	wire [7:0] mx   = lo[0] ? ~m : m;
	wire [8:0] sum9 = {1'b0, o_acc} + {1'b0, mx} + {8'h00, o_carry};
	wire [4:0] nib  = {1'b0, o_acc[3:0]} + {1'b0, mx[3:0]} + {4'h0, o_carry};

	// decimal correction direction follows the last add-with-carry or sub_borrow
	wire       dc_lo  = lsub_r ? !o_half_carry
			: (o_half_carry || o_acc[3:0] > `CAE_BCD_NIB_MAX);
	wire       dc_hi  = lsub_r ? !o_carry : (o_carry || o_acc > `CAE_BCD_MAX);
	wire [7:0] dc_adj = {(dc_hi ? `CAE_BCD_ADJ : 4'h0), (dc_lo ? `CAE_BCD_ADJ : 4'h0)};

	// execute stage: next architectural values
	reg [7:0]  acc_nxt;
	reg        c_nxt;
	reg        half_nxt;
	reg        irq_en_nxt;
	reg        lsub_nxt;
	reg [14:0] pc_nxt;
	reg        skip_c;
	reg        wr_c;
	reg        push_c;
	reg        tbl_c;
	reg [7:0]  wa_c;
	reg [7:0]  wd_c;
	reg        pw_c;
	reg [3:0]  pw_idx;
	reg [7:0]  pw_d;
	always @* begin
		acc_nxt = o_acc;
		c_nxt = o_carry;
		half_nxt = o_half_carry;
		irq_en_nxt = o_global_irq_enable;
		lsub_nxt = lsub_r;
		pc_nxt = o_pc;
		skip_c = 1'b0;
		wr_c = 1'b0;
		push_c = 1'b0;
		tbl_c = 1'b0;
		wa_c = daddr_r;
		wd_c = o_acc;
		pw_c = 1'b0;
		pw_idx = (hi == `CAE_G_PTRX) ? `CAE_IDX_X : `CAE_IDX_B;
		pw_d = opc_r[0] ? ptr - 8'h01 : ptr + 8'h01;
		case (hi)
		`CAE_G_AJUMP: pc_nxt = {o_pc[14:12], lo, op1_r};
		`CAE_G_ACALL: begin
			push_c = 1'b1;
			pc_nxt = {o_pc[14:12], lo, op1_r};
		end
		`CAE_G_NIBT: skip_c = (reg_b[3:0] == lo);
		`CAE_G_LDBS: begin
			pw_c = 1'b1;
			pw_idx = `CAE_IDX_B;
			pw_d = {4'h0, ~lo};
		end
		`CAE_G_MISC: begin
			if (lo[3]) begin
				wr_c = 1'b1;
				wd_c = opnd_r & ~bmask;
			end else if (opc_r == `CAE_OP_CLRA) begin
				acc_nxt = 8'h00;
			end else if (opc_r == `CAE_OP_SWAPA) begin
				acc_nxt = {o_acc[3:0], o_acc[7:4]};
			end else if (opc_r == `CAE_OP_DCOR) begin
				acc_nxt = lsub_r ? o_acc - dc_adj : o_acc + dc_adj;
				c_nxt = lsub_r ? o_carry : (o_carry || dc_hi);
			end
		end
		`CAE_G_BIT: begin
			if (lo[3]) begin
				wr_c = 1'b1;
				wd_c = opnd_r | bmask;
			end else begin
				skip_c = !opnd_r[lo[2:0]];
			end
		end
		`CAE_G_ALUB, `CAE_G_ALUI: begin
			if (!lo[3]) begin
				case (lo[2:0])
				3'h0, 3'h1: begin
					acc_nxt = sum9[7:0];
					c_nxt = sum9[8];
					half_nxt = nib[4];
					lsub_nxt = lo[0];
				end
				3'h2: skip_c = (o_acc != m);
				3'h3: skip_c = !(o_acc > m);
				3'h4: acc_nxt = o_acc + m;
				3'h5: acc_nxt = o_acc & m;
				3'h6: acc_nxt = o_acc ^ m;
				default: acc_nxt = o_acc | m;
				endcase
			end else if (is_pop) begin
				pc_nxt = {opnd2_r[6:0], opnd_r};
				pw_c = 1'b1;
				pw_idx = `CAE_IDX_STK;
				pw_d = stkp + 8'h02;
				skip_c = (opc_r == `CAE_OP_EXIT_SK);
				irq_en_nxt = (opc_r == `CAE_OP_IRQ_EXIT) ? 1'b1 : o_global_irq_enable;
			end else if (opc_r == `CAE_OP_IFC) begin
				skip_c = !o_carry;
			end else if (opc_r == `CAE_OP_IFNC) begin
				skip_c = o_carry;
			end else if (opc_r == `CAE_OP_INCA) begin
				acc_nxt = o_acc + 8'h01;
			end else if (opc_r == `CAE_OP_DECA) begin
				acc_nxt = o_acc - 8'h01;
			end else if (opc_r == `CAE_OP_LDAI) begin
				acc_nxt = op1_r;
			end else if (opc_r == `CAE_OP_XMD) begin
				acc_nxt = opnd_r;
				wr_c = 1'b1;
			end else if (opc_r == `CAE_OP_LDAMD) begin
				acc_nxt = opnd_r;
			end else if (hi == `CAE_G_ALUI && pmode) begin
				// load [b], [b+], [b-] with immediate
				wr_c = 1'b1;
				wa_c = reg_b;
				wd_c = op1_r;
				pw_c = pstep;
			end
		end
		`CAE_G_PTRB, `CAE_G_PTRX: begin
			if (pmode) begin
				acc_nxt = opnd_r;
				wr_c = !lo[3];
				pw_c = pstep;
			end else if (opc_r == `CAE_OP_RC || opc_r == `CAE_OP_SC) begin
				c_nxt = lo[0];
				half_nxt = lo[0];
			end else if (opc_r == `CAE_OP_TBL_LD || opc_r == `CAE_OP_TBL_JUMP) begin
				tbl_c = 1'b1;
			end else if (opc_r == `CAE_OP_LJUMP || opc_r == `CAE_OP_LCALL) begin
				pc_nxt = {op1_r[6:0], op2_r};
				push_c = lo[0];
			end else if (opc_r == `CAE_OP_ROT_RC) begin
				acc_nxt = {o_carry, o_acc[7:1]};
				c_nxt = o_acc[0];
				half_nxt = o_acc[0];
			end else if (opc_r == `CAE_OP_LDMDI) begin
				wr_c = 1'b1;
				wa_c = op1_r;
				wd_c = op2_r;
			end
		end
		`CAE_G_DECSK: begin
			wr_c = 1'b1;
			wd_c = opnd_r - 8'h01;
			skip_c = (opnd_r == 8'h01);
		end
		`CAE_G_LDREG: begin
			wr_c = 1'b1;
			wa_c = {`CAE_REG_PAGE, lo};
			wd_c = op1_r;
		end
		default: begin
			if (opc_r == `CAE_TRAP_OPC) begin
				push_c = 1'b1;
				pc_nxt = `CAE_TRAP_VEC;
			end else begin
				pc_nxt = o_pc + {{7{opc_r[7]}}, opc_r};
			end
		end
		endcase
		if (push_c) begin
			pw_c = 1'b1;
			pw_idx = `CAE_IDX_STK;
			pw_d = stkp - 8'h02;
		end
	end

	// one write port into the register page, never busy in both states
	wire       rf_we = (st_r == S_WR && wa0_r[7:4] == `CAE_REG_PAGE)
			|| (st_r == S_EXE && pw_c);
	wire [3:0] rf_wa = (st_r == S_WR) ? wa0_r[3:0] : pw_idx;
	wire [7:0] rf_wd = (st_r == S_WR) ? wd0_r : pw_d;

	// register page bytes f0..ff, pointers and stack_ptr among them
	genvar g;
	generate
		for (g = 0; g < 16; g = g + 1) begin : g_rf
			localparam integer IDX = g;
			always @(posedge i_clk or negedge i_reset_n) begin
				if (!i_reset_n)
					rf_r[g*8 +: 8] <= 8'h00;
				else if (rf_we && rf_wa == IDX[3:0])
					rf_r[g*8 +: 8] <= rf_wd;
			end
		end
	endgenerate

	// sequencer: fetch, operand read, execute, write back
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_r <= S_IF;
			opc_r <= 8'h00;
			op1_r <= 8'h00;
			op2_r <= 8'h00;
			cnt_r <= 2'd0;
			need_r <= 2'd0;
			skip_r <= 1'b0;
			daddr_r <= 8'h00;
			rdl_r <= 2'd0;
			opnd_r <= 8'h00;
			opnd2_r <= 8'h00;
			wa0_r <= 8'h00;
			wd0_r <= 8'h00;
			wa1_r <= 8'h00;
			wd1_r <= 8'h00;
			wcnt_r <= 2'd0;
			lsub_r <= 1'b0;
			o_prog_addr <= 15'h0000;
			o_prog_rd <= 1'b0;
			o_dmem_addr <= 8'h00;
			o_dmem_rd <= 1'b0;
			o_dmem_wr <= 1'b0;
			o_dmem_wdata <= 8'h00;
			o_acc <= 8'h00;
			o_pc <= 15'h0000;
			o_carry <= 1'b0;
			o_half_carry <= 1'b0;
			o_global_irq_enable <= 1'b0;
		end else begin
			o_prog_rd <= 1'b0;
			o_dmem_rd <= 1'b0;
			o_dmem_wr <= 1'b0;
			case (st_r)
			S_IF: begin
				o_prog_addr <= o_pc;
				o_prog_rd <= 1'b1;
				o_pc <= o_pc + 15'h0001;
				st_r <= S_IW;
			end
			S_IW: st_r <= S_IG;
			S_IG: begin
				if (cnt_r == 2'd0) begin
					opc_r <= pb;
					need_r <= op_len(pb);
				end else if (cnt_r == 2'd1) begin
					op1_r <= pb;
				end else begin
					op2_r <= pb;
				end
				if ((cnt_r == 2'd0) ? (op_len(pb) == 2'd0) : (cnt_r == need_r)) begin
					cnt_r <= 2'd0;
					skip_r <= 1'b0;
					// a skipped instruction is fetched whole, then dropped
					st_r <= skip_r ? S_IF : S_ADR;
				end else begin
					cnt_r <= cnt_r + 2'd1;
					st_r <= S_IF;
				end
			end
			S_ADR: begin
				daddr_r <= da_c;
				rdl_r <= rd_c;
				st_r <= (rd_c != 2'd0) ? S_DRQ : S_EXE;
			end
			S_DRQ: begin
				o_dmem_addr <= daddr_r;
				o_dmem_rd <= !is_reg;
				st_r <= S_DW;
			end
			S_DW: st_r <= S_DG;
			S_DG: begin
				opnd_r <= dval;
				opnd2_r <= opnd_r;
				// pops read the upper byte first, then step to the lower
				if (rdl_r == 2'd2)
					daddr_r <= daddr_r + 8'h01;
				rdl_r <= rdl_r - 2'd1;
				st_r <= (rdl_r == 2'd1) ? S_EXE : S_DRQ;
			end
			S_EXE: begin
				o_acc <= acc_nxt;
				o_carry <= c_nxt;
				o_half_carry <= half_nxt;
				o_global_irq_enable <= irq_en_nxt;
				lsub_r <= lsub_nxt;
				o_pc <= pc_nxt;
				skip_r <= skip_c;
				if (push_c) begin
					wa0_r <= stkp;
					wd0_r <= o_pc[7:0];
					wa1_r <= stkp - 8'h01;
					wd1_r <= {1'b0, o_pc[14:8]};
					wcnt_r <= 2'd2;
				end else begin
					wa0_r <= wa_c;
					wd0_r <= wd_c;
					wcnt_r <= 2'd1;
				end
				if (tbl_c)
					st_r <= S_TQ;
				else if (push_c || wr_c)
					st_r <= S_WR;
				else
					st_r <= S_IF;
			end
			S_WR: begin
				o_dmem_addr <= wa0_r;
				o_dmem_wdata <= wd0_r;
				o_dmem_wr <= (wa0_r[7:4] != `CAE_REG_PAGE);
				wa0_r <= wa1_r;
				wd0_r <= wd1_r;
				wcnt_r <= wcnt_r - 2'd1;
				st_r <= (wcnt_r == 2'd1) ? S_IF : S_WR;
			end
			S_TQ: begin
				o_prog_addr <= {o_pc[14:8], o_acc};
				o_prog_rd <= 1'b1;
				st_r <= S_TW;
			end
			S_TW: st_r <= S_TG;
			S_TG: begin
				if (opc_r == `CAE_OP_TBL_JUMP)
					o_pc <= {o_pc[14:8], pb};
				else
					o_acc <= pb;
				st_r <= S_IF;
			end
			default: st_r <= S_IF;
			endcase
		end
	end

endmodule // cae_core

// *** design/cae_defines.vh ***
`ifndef CAE_DEFINES_VH
`define CAE_DEFINES_VH

// register-memory page and pointer slots
`define CAE_REG_PAGE    4'hf
`define CAE_IDX_X       4'hc
`define CAE_IDX_STK     4'hd
`define CAE_IDX_B       4'he
// fill values, trap vector and program size
`define CAE_TRAP_OPC    8'h00
`define CAE_DATA_FILL   8'hff
`define CAE_TRAP_VEC    15'h00ff
`define CAE_PROG_BYTES  16'h8000
// decimal correction
`define CAE_BCD_NIB_MAX 4'h9
`define CAE_BCD_MAX     8'h99
`define CAE_BCD_ADJ     4'h6
// opcode groups by high nibble
`define CAE_G_AJUMP     4'h2
`define CAE_G_ACALL     4'h3
`define CAE_G_NIBT      4'h4
`define CAE_G_LDBS      4'h5
`define CAE_G_MISC      4'h6
`define CAE_G_BIT       4'h7
`define CAE_G_ALUB      4'h8
`define CAE_G_ALUI      4'h9
`define CAE_G_PTRB      4'ha
`define CAE_G_PTRX      4'hb
`define CAE_G_DECSK     4'hc
`define CAE_G_LDREG     4'hd
// single opcodes
`define CAE_OP_CLRA     8'h64
`define CAE_OP_SWAPA    8'h65
`define CAE_OP_DCOR     8'h66
`define CAE_OP_IFC      8'h88
`define CAE_OP_IFNC     8'h89
`define CAE_OP_INCA     8'h8a
`define CAE_OP_DECA     8'h8b
`define CAE_OP_EXIT_SK  8'h8d
`define CAE_OP_EXIT     8'h8e
`define CAE_OP_IRQ_EXIT 8'h8f
`define CAE_OP_LDAI     8'h98
`define CAE_OP_XMD      8'h9c
`define CAE_OP_LDAMD    8'h9d
`define CAE_OP_RC       8'ha0
`define CAE_OP_SC       8'ha1
`define CAE_OP_TBL_LD   8'ha4
`define CAE_OP_TBL_JUMP 8'ha5
`define CAE_OP_LJUMP    8'hac
`define CAE_OP_LCALL    8'had
`define CAE_OP_ROT_RC   8'hb0
`define CAE_OP_LDMDI    8'hbc
`endif

// *** test/cae_core_asserts.sv ***
`timescale 1ns/100ps
module cae_core_asserts #(
	parameter [15:0] PROG_BYTES = 16'h8000
) (
	input wire        i_clk,
	input wire        i_reset_n,
	input wire [14:0] o_prog_addr,
	input wire        o_prog_rd,
	input wire [7:0]  o_dmem_addr,
	input wire        o_dmem_rd,
	input wire        o_dmem_wr,
	input wire [7:0]  o_dmem_wdata,
	input wire        o_global_irq_enable
);
	reg [7:0] rd_age_r;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	// cycles since the last data read; saturates so a long idle never wraps
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			rd_age_r <= 8'hff;
		else if (o_dmem_rd)
			rd_age_r <= 8'h00;
		else if (rd_age_r != 8'hff)
			rd_age_r <= rd_age_r + 8'h01;
	end

	a_page_internal: assert property (
		(o_dmem_rd || o_dmem_wr) |-> o_dmem_addr[7:4] != 4'hf)
		else $error("register page access showed on the data port");
	a_strobes_apart: assert property (!(o_dmem_rd && o_dmem_wr))
		else $error("data read and write strobes together");
	a_fetch_spacing: assert property (o_prog_rd |=> !o_prog_rd [*2])
		else $error("program reads closer than three cycles");
	a_read_spacing: assert property (o_dmem_rd |=> !o_dmem_rd [*2])
		else $error("data reads closer than three cycles");
	a_push_descends: assert property (
		o_dmem_wr ##1 o_dmem_wr |-> o_dmem_addr == $past(o_dmem_addr) - 8'h01)
		else $error("second push byte not one below the first");
	a_push_high_part: assert property (
		o_dmem_wr ##1 o_dmem_wr |-> o_dmem_wdata[7] == 1'b0)
		else $error("upper pc part pushed with bit 7 set");
	a_trap_vector: assert property (
		(o_prog_rd && {1'b0, o_prog_addr} >= PROG_BYTES)
		|-> ##[3:40] (o_prog_rd && o_prog_addr == 15'h00ff))
		else $error("fetch outside program space did not reach the trap vector");
	a_irq_sticky: assert property (!$fell(o_global_irq_enable))
		else $error("interrupt enable cleared without reset");
	a_irq_after_pop: assert property (
		$rose(o_global_irq_enable) |-> rd_age_r <= 8'd8)
		else $error("interrupt enable set without a stack pop");
endmodule // cae_core_asserts

bind cae_core cae_core_asserts #(.PROG_BYTES(PROG_BYTES)) i_asserts (
	.i_clk              (i_clk),
	.i_reset_n          (i_reset_n),
	.o_prog_addr        (o_prog_addr),
	.o_prog_rd          (o_prog_rd),
	.o_dmem_addr        (o_dmem_addr),
	.o_dmem_rd          (o_dmem_rd),
	.o_dmem_wr          (o_dmem_wr),
	.o_dmem_wdata       (o_dmem_wdata),
	.o_global_irq_enable(o_global_irq_enable)
);

// *** test/cae_mem_model.sv ***
`timescale 1ns/100ps
module cae_mem_model (
	input  wire        i_clk,
	input  wire [14:0] i_prog_addr,
	input  wire        i_prog_rd,
	output logic [7:0] o_prog_data,
	input  wire [7:0]  i_dmem_addr,
	input  wire        i_dmem_rd,
	input  wire        i_dmem_wr,
	input  wire [7:0]  i_dmem_wdata,
	output logic [7:0] o_dmem_rdata,
	output logic       o_dmem_hit
);
	localparam [7:0] DATA_TOP = 8'h70; // first unimplemented data byte
	logic [7:0] prog [0:32767];
	logic [7:0] data [0:255];

	initial begin
		o_prog_data = 8'h00;
		o_dmem_rdata = 8'h00;
		o_dmem_hit = 1'b0;
	end

	// answers hold for one cycle only, then flip every cycle so a late
	// sample by the core cannot match by luck
	always @(posedge i_clk) begin
		o_prog_data <= #1 i_prog_rd ? prog[i_prog_addr] : ~o_prog_data;
		o_dmem_rdata <= #1 i_dmem_rd ? data[i_dmem_addr] : ~o_dmem_rdata;
		o_dmem_hit <= #1 i_dmem_rd ? (i_dmem_addr < DATA_TOP) : ~o_dmem_hit;
		if (i_dmem_wr && i_dmem_addr < DATA_TOP)
			data[i_dmem_addr] <= i_dmem_wdata;
	end
endmodule // cae_mem_model

// *** test/testbench.sv ***
`timescale 1ns/100ps
module testbench;
	localparam [15:0] PROG_LIM = 16'h4000; // small so the void fetch is reachable
	logic        i_clk;
	logic        i_reset_n;
	wire  [14:0] o_prog_addr;
	wire         o_prog_rd;
	wire  [7:0]  i_prog_data;
	wire  [7:0]  o_dmem_addr;
	wire         o_dmem_rd;
	wire         o_dmem_wr;
	wire  [7:0]  o_dmem_wdata;
	wire  [7:0]  i_dmem_rdata;
	wire         i_dmem_hit;
	wire  [7:0]  o_acc;
	wire  [14:0] o_pc;
	wire         o_carry;
	wire         o_half_carry;
	wire         o_global_irq_enable;
	int          errors;
	int          total_checks;

	cae_core #(.PROG_BYTES(PROG_LIM)) i_dut (
		.i_clk(i_clk), .i_reset_n(i_reset_n), .o_prog_addr(o_prog_addr),
		.o_prog_rd(o_prog_rd), .i_prog_data(i_prog_data), .o_dmem_addr(o_dmem_addr),
		.o_dmem_rd(o_dmem_rd), .o_dmem_wr(o_dmem_wr), .o_dmem_wdata(o_dmem_wdata),
		.i_dmem_rdata(i_dmem_rdata), .i_dmem_hit(i_dmem_hit), .o_acc(o_acc), .o_pc(o_pc),
		.o_carry(o_carry), .o_half_carry(o_half_carry),
		.o_global_irq_enable(o_global_irq_enable));
	cae_mem_model i_mem (
		.i_clk(i_clk), .i_prog_addr(o_prog_addr), .i_prog_rd(o_prog_rd),
		.o_prog_data(i_prog_data), .i_dmem_addr(o_dmem_addr), .i_dmem_rd(o_dmem_rd),
		.i_dmem_wr(o_dmem_wr), .i_dmem_wdata(o_dmem_wdata), .o_dmem_rdata(i_dmem_rdata),
		.o_dmem_hit(i_dmem_hit));

	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
		total_checks++;
		if (seen !== want) begin
			errors++;
			$display("wrong value at %0t ns: %s is %h, expected %h", $time, what, seen, want);
		end
	endtask

	task automatic conclude();
		$display("checks %0d, mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// unwritten program bytes are a jump to self, so stray flow hangs and times out
	task automatic restart();
		i_reset_n = 1'b0;
		foreach (i_mem.prog[k])
			i_mem.prog[k] = 8'hff;
		foreach (i_mem.data[k])
			i_mem.data[k] = 8'h00;
		repeat (4) @(posedge i_clk);
		#1 i_reset_n = 1'b1;
	endtask

	task automatic load(input logic [14:0] at, input logic [7:0] b[$]);
		foreach (b[k])
			i_mem.prog[at + 15'(k)] = b[k];
	endtask

	task automatic run(input logic [14:0] halt);
		int n;
		for (n = 0; n < 4000; n++) begin
			@(posedge i_clk);
			#2;
			if (o_prog_rd === 1'b1 && o_prog_addr === halt)
				break;
		end
		if (n == 4000) begin
			errors++;
			$display("wrong value at %0t ns: halt %h never fetched", $time, halt);
			conclude();
		end else begin
			repeat (8) @(posedge i_clk);
			#2;
		end
	endtask

	task automatic mem_list(input logic [7:0] adr[$], input logic [7:0] val[$]);
		foreach (adr[k])
			check({8'h00, i_mem.data[adr[k]]}, {8'h00, val[k]}, "data byte");
	endtask

	task automatic test_operands();
		restart();
		i_mem.data[8'h20] = 8'h11;
		i_mem.data[8'h21] = 8'h22;
		i_mem.data[8'h03] = 8'h33;
		load(15'h0000, '{8'hde, 8'h20, 8'haa, 8'h9c, 8'h40, 8'hab, 8'h9c, 8'h41, 8'hae,
			8'h9c, 8'h42, 8'h98, 8'h77, 8'ha2, 8'h5c, 8'hae, 8'h9c, 8'h44, 8'hdc, 8'h21,
			8'hbe, 8'h9c, 8'h45, 8'h9d, 8'h90, 8'h9c, 8'h46, 8'hbc, 8'h43, 8'h5a, 8'h9d,
			8'h20, 8'hff});
		run(15'h0020);
		mem_list('{8'h40, 8'h41, 8'h42, 8'h20, 8'h44, 8'h45, 8'h46, 8'h43},
			'{8'h11, 8'h22, 8'h11, 8'h77, 8'h33, 8'h22, 8'hff, 8'h5a});
		check({8'h00, o_acc}, 16'h0077, "accumulator");
		$display("test operands done");
	endtask

	// each conditional but the two decrement skips guards a bit set in one byte, so the byte shows which ran
	task automatic test_skips();
		restart();
		load(15'h0000, '{8'hde, 8'h50, 8'h98, 8'h05, 8'h92, 8'h05, 8'h78, 8'h92, 8'h06,
			8'h79, 8'h93, 8'h04, 8'h7a, 8'h93, 8'h05, 8'h7b, 8'h40, 8'h7c, 8'h41, 8'h7d,
			8'h70, 8'h7e, 8'h71, 8'h7f, 8'h6a, 8'h98, 8'h00, 8'hd1, 8'h02, 8'hc1, 8'h8a,
			8'hc1, 8'h8a, 8'ha1, 8'hb0, 8'hb0, 8'h89, 8'h7f, 8'h9c, 8'h51, 8'ha0, 8'h98,
			8'h58, 8'h90, 8'h69, 8'h66, 8'hff});
		run(15'h002e);
		mem_list('{8'h50}, '{8'he1});
		mem_list('{8'h51}, '{8'hc0});
		check({8'h00, o_acc}, 16'h0027, "accumulator");
		check({15'h0000, o_carry}, 16'h0001, "carry");
		check({15'h0000, o_half_carry}, 16'h0001, "half carry");
		$display("test skips done");
	endtask

	task automatic test_transfers();
		restart();
		load(15'h0000, '{8'hdd, 8'h6f, 8'h98, 8'h11, 8'h1f});
		load(15'h0024, '{8'hac, 8'h12, 8'h34});
		load(15'h1234, '{8'h2a, 8'hbc});
		load(15'h1abc, '{8'h36, 8'h00, 8'hbc, 8'h61, 8'hee, 8'had, 8'h20, 8'h00, 8'he1});
		load(15'h1600, '{8'ha4, 8'h9c, 8'h60, 8'h8d});
		load(15'h2000, '{8'h00, 8'h98, 8'h40, 8'ha5});
		i_mem.prog[15'h1611] = 8'h5a;
		i_mem.prog[15'h2040] = 8'h10;
		i_mem.prog[15'h2010] = 8'h8e;
		i_mem.prog[15'h00ff] = 8'h8f;
		run(15'h1aa6);
		mem_list('{8'h60, 8'h61}, '{8'h5a, 8'h00});
		// each return gives back two bytes, so the long call reuses the slots of the first call
		mem_list('{8'h6f, 8'h6e, 8'h6d, 8'h6c, 8'h6b, 8'h6a},
			'{8'hc4, 8'h1a, 8'h01, 8'h20, 8'h00, 8'h00});
		check({15'h0000, o_global_irq_enable}, 16'h0001, "irq enable");
		check({8'h00, o_acc}, 16'h0040, "accumulator");
		$display("test transfers done");
	endtask

	// a byte outside the program space must act as a trap, not as its content
	task automatic test_void_fetch();
		restart();
		load(15'h0000, '{8'hdd, 8'h6f, 8'hac, 8'h50, 8'h00});
		i_mem.prog[15'h5000] = 8'h98;
		run(15'h00ff);
		mem_list('{8'h6f, 8'h6e}, '{8'h01, 8'h50});
		check({15'h0000, o_global_irq_enable}, 16'h0000, "irq enable");
		check({8'h00, o_acc}, 16'h0000, "accumulator");
		// eight cycles after the vector fetch the self jump sits in execute
		check({1'b0, o_pc}, 16'h0100, "program counter");
		$display("test void fetch done");
	endtask

	initial begin
		errors = 0;
		total_checks = 0;
		i_reset_n = 1'b0;
		test_operands();
		test_skips();
		test_transfers();
		test_void_fetch();
		conclude();
	end
endmodule // testbench
